/* pesc_consts.svh */
// offsets, field positions, select codes and reset values of the event counter
`ifndef PESC_CONSTS_SVH
`define PESC_CONSTS_SVH

// register byte offsets
`define PESC_OFS_EVENT_SELECT_CTRL 4'h0
`define PESC_OFS_COUNTER_CONFIG_CTRL 4'h4
`define PESC_OFS_COUNT 4'h8
`define PESC_OFS_STATUS 4'hC

// event_select_ctrl fields
`define PESC_ES_SEL7_HI 31
`define PESC_ES_SEL6_HI 30
`define PESC_ES_SEL_LO 25
`define PESC_ES_MASK_HI 24
`define PESC_ES_MASK_LO 9
`define PESC_ES_RESET 32'h0000_0000
`define PESC_ES_WMASK 32'hFFFF_FE00

// counter_config_ctrl fields
`define PESC_CC_SEL_HI 15
`define PESC_CC_SEL_LO 13
`define PESC_CC_ENABLE 12
`define PESC_CC_RESET 32'h0000_0000
`define PESC_CC_WMASK 32'h0000_F000

// event select codes
`define PESC_CODE_SEQ_XFER 7'h05
`define PESC_CODE_UOPQ_WR 7'h09
`define PESC_CODE_MISPRED_BR 6'h05
`define PESC_CODE_RETIRED_BR 6'h04
`define PESC_CC_SEL_FRONT 3'h0
`define PESC_CC_SEL_BRANCH 3'h2

// mask bit positions, relative to the mask field
`define PESC_M_SEQ_XFER 0
`define PESC_M_SRC_BUILD 0
`define PESC_M_SRC_DELIVER 1
`define PESC_M_SRC_ROM 2
`define PESC_M_BR_COND 1
`define PESC_M_BR_CALL 2
`define PESC_M_BR_RETURN 3
`define PESC_M_BR_INDIRECT 4

`endif

/* pesc_pkg.sv */
// types shared by the event counter
`default_nettype none
package pesc_pkg;

  typedef enum logic [2:0] {
    PESC_EV_NONE,
    PESC_EV_SEQ_XFER,
    PESC_EV_UOPQ_WR,
    PESC_EV_MISPRED_BR,
    PESC_EV_RETIRED_BR
  } pesc_event_type;

  // pipeline occurrences, one cycle each
  typedef struct packed {
    logic seq_transfer_bit;
    logic [1:0] src_trace_build;
    logic [1:0] src_trace_deliver;
    logic [1:0] src_rom;
    logic br_valid;
    logic br_mispred;
    logic br_cond;
    logic br_call_direct;
    logic br_call_indirect;
    logic br_return;
    logic br_jump_indirect;
  } pesc_events_type;

endpackage
`default_nettype wire

/* pesc_top.sv */
// event selection and counting with an avalon-mm register slave
//
// Function
// - sequencer-transfer code 05H, mask bit0 counts transfers
// - code 09H counts valid uop queue writes
// - mask bit0 counts trace-build mode writes
// - mask bit1 counts trace-delivery mode writes
// - mask bit2 counts microcode rom writes
// - mispredicted branches: code 05H, config 02H
// - mispredict mask bits 1-4 select branch types
// - mispredict count may include rebuild/clear reports
// - retired branch event counts all outcomes
// - retired branch code 04H, bit2 all calls
`timescale 1ns/1ps
`default_nettype none
`include "pesc_consts.svh"

module pesc_top #(
  parameter int CNT_W = 32
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire pesc_pkg::pesc_events_type i_events,
  output logic [CNT_W-1:0] o_count,
  output logic o_counting
);

  // counter wider than the bus word or too narrow to be useful is refused
  if (CNT_W < 8 || CNT_W > 32) begin : g_bad_cnt_w
    $error("pesc_top: CNT_W must lie in 8..32");
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [2:0] count2(input logic [1:0] n, input logic en);
    return en ? {1'b0, n} : 3'h0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [31:0] event_select_ctrl_q;
  logic [31:0] counter_config_ctrl_q;
  logic [CNT_W-1:0] count_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic counting_q;
  logic acc_now;
  logic wr_now;
  logic [31:0] count_word;
  pesc_pkg::pesc_event_type evt_sel;

  assign acc_now = (i_avs_read || i_avs_write) && !wait_q;
  assign wr_now = i_avs_write && !wait_q;
  assign count_word = 32'(count_q);

  // one wait state: a write lands at the edge where waitrequest is low, read data is taken at the edge before it
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      wait_q <= 1'b1;
    end else if (i_clk_en) begin
      if (acc_now) begin
        wait_q <= 1'b1;
      end else if (i_avs_read || i_avs_write) begin
        wait_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      rdata_q <= 32'h0000_0000;
    end else if (i_clk_en && wait_q && i_avs_read) begin
      unique case (i_avs_address)
        `PESC_OFS_EVENT_SELECT_CTRL: rdata_q <= event_select_ctrl_q;
        `PESC_OFS_COUNTER_CONFIG_CTRL: rdata_q <= counter_config_ctrl_q;
        `PESC_OFS_COUNT: rdata_q <= count_word;
        `PESC_OFS_STATUS: rdata_q <= {29'h0000_0000, evt_sel};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // software programs type choice through the mask field
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      event_select_ctrl_q <= `PESC_ES_RESET;
    end else if (i_clk_en && wr_now && i_avs_address == `PESC_OFS_EVENT_SELECT_CTRL) begin
      event_select_ctrl_q <= merge_bytes(event_select_ctrl_q, i_avs_writedata,
                                         i_avs_byteenable) & `PESC_ES_WMASK;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      counter_config_ctrl_q <= `PESC_CC_RESET;
    end else if (i_clk_en && wr_now && i_avs_address == `PESC_OFS_COUNTER_CONFIG_CTRL) begin
      counter_config_ctrl_q <= merge_bytes(counter_config_ctrl_q, i_avs_writedata,
                                           i_avs_byteenable) & `PESC_CC_WMASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event selection

  logic [6:0] sel7;
  logic [5:0] sel6;
  logic [15:0] emask;
  logic [2:0] cc_sel;
  logic cc_en;

  assign sel7 = event_select_ctrl_q[`PESC_ES_SEL7_HI:`PESC_ES_SEL_LO];
  assign sel6 = event_select_ctrl_q[`PESC_ES_SEL6_HI:`PESC_ES_SEL_LO];
  assign emask = event_select_ctrl_q[`PESC_ES_MASK_HI:`PESC_ES_MASK_LO];
  assign cc_sel = counter_config_ctrl_q[`PESC_CC_SEL_HI:`PESC_CC_SEL_LO];
  assign cc_en = counter_config_ctrl_q[`PESC_CC_ENABLE];

  // same 05H code is split apart by the config select
  always_comb begin
    evt_sel = pesc_pkg::PESC_EV_NONE;
    if (cc_sel == `PESC_CC_SEL_FRONT) begin
      if (sel7 == `PESC_CODE_SEQ_XFER) begin
        evt_sel = pesc_pkg::PESC_EV_SEQ_XFER;
      end else if (sel7 == `PESC_CODE_UOPQ_WR) begin
        evt_sel = pesc_pkg::PESC_EV_UOPQ_WR;
      end
    end else if (cc_sel == `PESC_CC_SEL_BRANCH) begin
      if (sel6 == `PESC_CODE_MISPRED_BR) begin
        evt_sel = pesc_pkg::PESC_EV_MISPRED_BR;
      end else if (sel6 == `PESC_CODE_RETIRED_BR) begin
        evt_sel = pesc_pkg::PESC_EV_RETIRED_BR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // increment per cycle

  logic [3:0] uopq_inc;
  logic br_any_mispred;
  logic br_any_retired;
  logic [3:0] inc;

  always_comb begin
    uopq_inc = 4'(count2(i_events.src_trace_build, emask[`PESC_M_SRC_BUILD]))
             + 4'(count2(i_events.src_trace_deliver, emask[`PESC_M_SRC_DELIVER]))
             + 4'(count2(i_events.src_rom, emask[`PESC_M_SRC_ROM]));
  end

  // one count per branch even when several chosen types match
  always_comb begin
    br_any_mispred = (emask[`PESC_M_BR_COND] && i_events.br_cond)
                  || (emask[`PESC_M_BR_CALL] && i_events.br_call_indirect)
                  || (emask[`PESC_M_BR_RETURN] && i_events.br_return)
                  || (emask[`PESC_M_BR_INDIRECT] && (i_events.br_return
                      || i_events.br_call_indirect || i_events.br_jump_indirect));
    br_any_retired = (emask[`PESC_M_BR_COND] && i_events.br_cond)
                  || (emask[`PESC_M_BR_CALL] && (i_events.br_call_direct
                      || i_events.br_call_indirect))
                  || (emask[`PESC_M_BR_RETURN] && i_events.br_return)
                  || (emask[`PESC_M_BR_INDIRECT] && (i_events.br_return
                      || i_events.br_call_indirect || i_events.br_jump_indirect));
  end

  always_comb begin
    inc = 4'h0;
    unique case (evt_sel)
      pesc_pkg::PESC_EV_NONE: inc = 4'h0;
      pesc_pkg::PESC_EV_SEQ_XFER:
        inc = {3'h0, emask[`PESC_M_SEQ_XFER] && i_events.seq_transfer_bit};
      pesc_pkg::PESC_EV_UOPQ_WR: inc = uopq_inc;
      // mispredict reports raised by rebuilds or clears are not filtered
      pesc_pkg::PESC_EV_MISPRED_BR:
        inc = {3'h0, i_events.br_valid && i_events.br_mispred && br_any_mispred};
      // taken and not taken alike
      pesc_pkg::PESC_EV_RETIRED_BR:
        inc = {3'h0, i_events.br_valid && br_any_retired};
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter

  // a software write to the count wins over an increment in that cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      count_q <= '0;
    end else if (i_clk_en) begin
      if (wr_now && i_avs_address == `PESC_OFS_COUNT) begin
        count_q <= CNT_W'(merge_bytes(count_word, i_avs_writedata, i_avs_byteenable));
      end else if (cc_en) begin
        count_q <= count_q + CNT_W'(inc);
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      counting_q <= 1'b0;
    end else if (i_clk_en) begin
      counting_q <= cc_en && (evt_sel != pesc_pkg::PESC_EV_NONE);
    end
  end

  assign o_avs_readdata = rdata_q;
  assign o_avs_waitrequest = wait_q;
  assign o_count = count_q;
  assign o_counting = counting_q;

endmodule

`default_nettype wire

/* pesc_top_assertions.sv */
// port checker of the event counter
`timescale 1ns/1ps
`default_nettype none
module pesc_chk #(
  parameter int CNT_W = 32
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire pesc_pkg::pesc_events_type i_events,
  input wire logic [CNT_W-1:0] o_count
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  wire logic wr_done = i_avs_write && !o_avs_waitrequest;
  wire logic no_uop = {i_events.src_trace_build, i_events.src_trace_deliver, i_events.src_rom} == 6'h0;
  sequence s_req;
    i_clk_en && (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence s_idle_step;
    i_clk_en && !wr_done;
  endsequence
  //////////////////////////////////////////////////////////////////////////////
  AST_WAIT_ONE: assert property (s_req |=> !o_avs_waitrequest)
    else $error("request not answered after one wait cycle");
  AST_WAIT_PULSE: assert property (i_clk_en && !o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_RESET: assert property ($past(i_reset) && $past(i_clk_en) |-> o_count == '0 && o_avs_waitrequest && o_avs_readdata == 32'h0)
    else $error("state not cleared by reset");
  AST_FREEZE: assert property (!i_clk_en |=> $stable(o_count) && $stable(o_avs_waitrequest))
    else $error("state moved with clock enable low");
  AST_NO_EVENT: assert property (s_idle_step and i_events == '0 |=> $stable(o_count))
    else $error("count moved without any event");
  AST_STEP: assert property (s_idle_step |=> CNT_W'(o_count - $past(o_count)) <= 9)
    else $error("count step above nine");
  AST_ONE_PER: assert property (s_idle_step and no_uop |=> CNT_W'(o_count - $past(o_count)) <= 1)
    else $error("count step above one");
  AST_UNMAPPED: assert property (i_avs_read && !o_avs_waitrequest && i_avs_address[1:0] != 2'h0 |-> o_avs_readdata == 32'h0)
    else $error("unmapped read not zero");
endmodule
`default_nettype wire

/* pesc_pipe_model.sv */
// pipeline event source model
`timescale 1ns/1ps
`default_nettype none
module pesc_pipe_model (
  input wire logic i_ref_clk,
  input wire logic [13:0] i_raw,
  output var pesc_pkg::pesc_events_type o_events
);
  // reports pass unfiltered, repeats included
  always_ff @(posedge i_ref_clk) begin
    o_events <= pesc_pkg::pesc_events_type'(i_raw);
  end
endmodule
`default_nettype wire

/* tb_pesc_top.sv */
// self-checking bench of the event counter
`timescale 1ns/1ps
`default_nettype none
module tb_pesc_top;
  logic i_ref_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_clk_en = 1'b1;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] be = 4'hF;
  logic [31:0] rdat;
  logic [31:0] rd_v;
  logic [31:0] es;
  logic [31:0] cnt;
  logic wreq;
  logic cnting;
  logic [13:0] raw = 14'h0;
  logic [15:0] msk;
  pesc_pkg::pesc_events_type ev;
  int failures = 0;
  int check_count = 0;
  int exp_cnt = 0;
  int mode = 0;
  bit arm = 0;
  always #4 i_ref_clk = ~i_ref_clk;
  pesc_pipe_model u_pipe (.i_ref_clk, .i_raw(raw), .o_events(ev));
  pesc_top dut (.i_ref_clk, .i_reset, .i_clk_en, .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(be), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq), .i_events(ev), .o_count(cnt), .o_counting(cnting));
  //////////////////////////////////////////////////////////////////////////////
  function automatic int inc(input int m, input logic [15:0] k, input pesc_pkg::pesc_events_type e);
    logic b;
    b = (k[1] & e.br_cond) | (k[3] & e.br_return)
      | (k[4] & (e.br_return | e.br_call_indirect | e.br_jump_indirect));
    case (m)
      0: return k[0] & e.seq_transfer_bit;
      1: return (k[0] ? e.src_trace_build : 0) + (k[1] ? e.src_trace_deliver : 0)
        + (k[2] ? e.src_rom : 0);
      2: return e.br_valid & e.br_mispred & (b | (k[2] & e.br_call_indirect));
      default: return e.br_valid & (b | (k[2] & (e.br_call_indirect | e.br_call_direct)));
    endcase
  endfunction
  always @(posedge i_ref_clk) if (arm && i_clk_en) exp_cnt += inc(mode, msk, ev);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= d;
    do @(posedge i_ref_clk); while (wreq !== 1'b0);
    rd_v = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd_v, e);
  endtask
  task automatic summarize();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // about 1000 cycles expected
  initial begin
    #100000;
    failures++;
    summarize();
  end
  initial begin
    void'($urandom(32'h5D0D9960));
    repeat (16) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    for (int a = 0; a < 16; a += 2) rchk(4'(a), 32'h0);
    bus(1'b1, 4'h0, 32'hFFFFFFFF);
    rchk(4'h0, 32'hFFFFFE00);
    bus(1'b1, 4'h4, 32'hFFFFFFFF);
    rchk(4'h4, 32'h0000F000);
    rchk(4'hC, 32'h0);
    bus(1'b1, 4'h2, 32'hFFFFFFFF);
    be <= 4'h2;
    bus(1'b1, 4'h8, 32'h12345678);
    be <= 4'hF;
    rchk(4'h8, 32'h00005600);
    for (int m = 0; m < 4; m++) begin
      for (int r = 0; r < 3; r++) begin
        msk = (r == 0) ? 16'($urandom()) : (r == 1) ? 16'hFFFF : 16'h0;
        mode = m;
        es = {m == 0 ? 7'h05 : m == 1 ? 7'h09 : {1'($urandom()), m == 2 ? 6'h05 : 6'h04},
          msk, 9'h0};
        bus(1'b1, 4'h8, 32'h0);
        bus(1'b1, 4'h0, es);
        bus(1'b1, 4'h4, m < 2 ? 32'h1000 : 32'h5000);
        exp_cnt = 0;
        arm = 1;
        repeat (60) begin
          @(posedge i_ref_clk);
          raw <= 14'($urandom());
          i_clk_en <= ($urandom() % 8) != 0;
        end
        @(posedge i_ref_clk);
        raw <= 14'h0;
        i_clk_en <= 1'b1;
        repeat (3) @(posedge i_ref_clk);
        arm = 0;
        chk(cnt, 32'(exp_cnt));
        chk({31'h0, cnting}, 32'h1);
        rchk(4'hC, 32'(m + 1));
        rchk(4'h8, 32'(exp_cnt));
      end
    end
    i_reset <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    @(posedge i_ref_clk);
    chk(cnt, 32'h0);
    chk({31'h0, cnting}, 32'h0);
    summarize();
  end
endmodule
bind pesc_top pesc_chk #(.CNT_W(CNT_W)) u_chk (.i_ref_clk, .i_reset, .i_clk_en,
  .i_avs_address, .i_avs_read, .i_avs_write, .o_avs_readdata, .o_avs_waitrequest,
  .i_events, .o_count);
`default_nettype wire
